// File: dcpt_pins_model.sv
// Purpose: far side of the timer: capture and event sources, slow clock
// Assumes: the bench asks for pin levels through want_a and want_b
// Notes:   a requested level is held two clocks before it may move again
`timescale 1ns/1ns
`default_nettype none
module dcpt_pins_model (
  // system clock
  input  wire logic clk,
  // levels asked for by the bench
  input  wire logic want_a,
  input  wire logic want_b,
  // design drive of pin a
  input  wire logic pin_a_out,
  input  wire logic pin_a_oe,
  // levels seen by the design
  output logic      pin_a,
  output logic      pin_b,
  output logic      slow_clk
);
  logic drv_a = 1'b0; // source level on pin a
  logic drv_b = 1'b0; // source level on pin b
  int   age_a = 0;    // cycles since pin a moved
  int   age_b = 0;    // cycles since pin b moved

  // slow clock at one eighth of clk, edges never on a clk edge
  initial begin
    slow_clk = 1'b0;
    #2;
    forever #40 slow_clk = ~slow_clk;
  end

  // the design owns pin a while its enable is high
  assign pin_a = pin_a_oe ? pin_a_out : drv_a;
  assign pin_b = drv_b;

  // move a level just after an edge, never before it stood two clocks
  always @(posedge clk) begin
    age_a <= age_a + 1;
    age_b <= age_b + 1;
    if (age_a > 0 && want_a != drv_a) begin
      drv_a <= #1 want_a;
      age_a <= 0;
    end
    if (age_b > 0 && want_b != drv_b) begin
      drv_b <= #1 want_b;
      age_b <= 0;
    end
  end
endmodule
`default_nettype wire

// File: dcpt_pkg.sv
// Purpose: shared types and constants of the dual counter pwm/capture timer
// Assumes: one system clock, configuration written as a whole word by software
// Notes:   no register bus; configuration travels as one packed struct
package dcpt_pkg;

  // counter and prescaler widths
  localparam int          CNT_W     = 16;
  localparam int          PRSC_W    = 5;
  // value loaded by a capture preset and by a free running underflow
  localparam logic [15:0] CNT_PRESET = 16'hFFFF;
  // prescaler count at reset
  localparam logic [4:0]  PRSC_RST  = 5'h00;
  // counter and capture register value at reset
  localparam logic [15:0] CNT_RST   = 16'h0000;

  // pending flag positions
  localparam int PEND_A = 0;
  localparam int PEND_B = 1;
  localparam int PEND_C = 2;
  localparam int PEND_D = 3;

  // synchronised pin positions
  localparam int SYN_PIN_A = 0;
  localparam int SYN_PIN_B = 1;
  localparam int SYN_SLOW  = 2;
  localparam int SYN_W     = 3;

  // operating mode
  typedef enum logic {MODE_PWM, MODE_CAPTURE} dcpt_mode_e;

  // counter clock source
  typedef enum logic [2:0] {
    SRC_NONE, SRC_PRESC, SRC_EVENT, SRC_ACCUM, SRC_SLOW
  } dcpt_src_e;

  // software write target
  typedef enum logic [2:0] {
    TGT_NONE, TGT_CRA, TGT_CRB, TGT_CNT1, TGT_CNT2
  } dcpt_tgt_e;

  // configuration word
  typedef struct packed {
    dcpt_mode_e        mode;          // pwm or dual capture
    dcpt_src_e         sel_one;       // counter one source
    dcpt_src_e         sel_two;       // counter two source
    logic [PRSC_W-1:0] prescaler_value; // divide by value plus one
    logic              evt_rising;    // pin b event edge: 1 rising
    logic              accum_high;    // pin b accumulate level: 1 high
    logic              cap_a_rising;  // pin a capture edge: 1 rising
    logic              cap_b_rising;  // pin b capture edge: 1 rising
    logic              preset_a;      // preset counter one on capture a
    logic              preset_b;      // preset counter one on capture b
    logic              pin_a_function_enable; // drive pwm on pin a
    logic              pwm_initial_level;     // pin a level before toggle
    logic [3:0]        irq_enable;    // enables a, b, c, d
  } dcpt_cfg_s;

  // configuration after reset: both counters halted
  localparam dcpt_cfg_s CFG_RST = '{
    mode: MODE_PWM, sel_one: SRC_NONE, sel_two: SRC_NONE,
    prescaler_value: PRSC_RST, default: '0};

  // software data write
  typedef struct packed {
    dcpt_tgt_e        target;  // what is written, none when idle
    logic [CNT_W-1:0] data;    // value written
  } dcpt_wr_s;

endpackage

// File: dcpt_sync_edge.sv
// Purpose: two-stage synchroniser with edge detection for several pins
// Assumes: inputs are asynchronous to clk
// Notes:   edges are detected on the second and third stages only
`timescale 1ns/1ns
`default_nettype none
module dcpt_sync_edge #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // asynchronous inputs
  input  wire logic [W-1:0] async_in,
  // synchronised level and edges
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta;   // first stage, read only by the second
  logic [W-1:0] sync;   // second stage
  logic [W-1:0] prev;   // third stage for edge detection

  // register all three stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else begin
      meta <= async_in;
      sync <= meta;
      prev <= sync;
    end
  end

  // level and one-cycle edge pulses
  always_comb begin
    level = sync;
    rise  = sync & ~prev;
    fall  = ~sync & prev;
  end

endmodule
`default_nettype wire

// File: dcpt_timer.sv
// Purpose: dual 16-bit counter timer unit with pwm and dual capture modes
// Assumes: pins and the slow clock are asynchronous and pass two flip-flops
// Notes:   counting simply halts while clk is stopped
//
// Summary of operation
// - two 16-bit counters, two reload/capture registers
// - per-counter source: none, prescaler, event, accumulate, slow
// - 5-bit prescaler ticks every value plus one
// - reset clears prescaler value and down counter
// - event mode counts chosen edge of pin b
// - accumulate counts prescaler ticks while pin b active
// - capture mode stops event and accumulate sources
// - slow clock synchronised; at most quarter rate
// - counters hold while system clock stopped
// - timers disabled after reset until configured
// - pwm mode reloads counter one alternately a, b
// - every pwm start reloads first from a
// - pin a toggles on each pwm mode counter one underflow
// - reload from a sets flag a, b sets b
// - pwm mode counter two underflow sets flag d
// - capture edges copy counter one into a, b
// - preset option loads FFFF after capture
// - capture a, b and underflow set flags a, b, c
// - capture mode counter two underflow sets flag d
// - flags a, b, c drive irq one; d irq two
// - pin a starts at initial level programmed before the start write
`timescale 1ns/1ns
`default_nettype none
module dcpt_timer (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // configuration from software
  input  wire logic                        cfg_wr,
  input  wire dcpt_pkg::dcpt_cfg_s         cfg_in,
  input  wire dcpt_pkg::dcpt_wr_s          wr_in,
  input  wire logic [3:0]                  pend_clr,
  // external pins and slow clock
  input  wire logic                        timer_pin_a_in,
  input  wire logic                        timer_pin_b_in,
  input  wire logic                        low_speed_clock,
  output logic                             timer_pin_a_out,
  output logic                             timer_pin_a_oe,
  // state shown to software
  output logic [dcpt_pkg::CNT_W-1:0]       counter_one,
  output logic [dcpt_pkg::CNT_W-1:0]       counter_two,
  output logic [dcpt_pkg::CNT_W-1:0]       reload_capture_a,
  output logic [dcpt_pkg::CNT_W-1:0]       reload_capture_b,
  output logic [3:0]                       pending_flags,
  output logic                             timer_irq_one,
  output logic                             timer_irq_two
);

  localparam int CW = dcpt_pkg::CNT_W;
  localparam logic [CW-1:0] CNT_ZERO = dcpt_pkg::CNT_RST; // underflow test value

  dcpt_pkg::dcpt_cfg_s            cfg;        // active configuration
  dcpt_pkg::dcpt_cfg_s            next_cfg;
  logic [dcpt_pkg::PRSC_W-1:0]    presc_cnt;  // prescaler down counter
  logic [dcpt_pkg::PRSC_W-1:0]    next_presc_cnt;
  logic                           presc_tick; // one-cycle prescaler output
  logic [dcpt_pkg::SYN_W-1:0]     syn_level;  // synchronised pins
  logic [dcpt_pkg::SYN_W-1:0]     syn_rise;
  logic [dcpt_pkg::SYN_W-1:0]     syn_fall;
  logic                           tick_one;   // counter one clock enable
  logic                           tick_two;   // counter two clock enable
  logic                           cap_a_evt;  // valid capture edge on pin a
  logic                           cap_b_evt;  // valid capture edge on pin b
  logic                           restart;    // pwm sequence restarts at a
  logic                           use_b;      // next pwm reload from b
  logic                           next_use_b;
  logic [CW-1:0]                  next_cnt1;
  logic [CW-1:0]                  next_cnt2;
  logic [CW-1:0]                  next_cra;
  logic [CW-1:0]                  next_crb;
  logic [3:0]                     next_pend;
  logic [3:0]                     pend_set;   // events of this cycle
  logic                           next_pin_a;
  logic                           next_oe;
  logic                           next_irq1;
  logic                           next_irq2;
  logic                           pwm_mode;

  // synchronise pin a, pin b and the slow clock
  dcpt_sync_edge #(
    .W (dcpt_pkg::SYN_W)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({low_speed_clock, timer_pin_b_in, timer_pin_a_in}),
    .level    (syn_level),
    .rise     (syn_rise),
    .fall     (syn_fall)
  );

  // clock enable for one counter from its selected source
  function automatic logic src_tick(input dcpt_pkg::dcpt_src_e sel,
                                    input logic cap, input logic ptick,
                                    input logic b_edge, input logic b_act,
                                    input logic slow);
    case (sel)
      dcpt_pkg::SRC_NONE:  src_tick = 1'b0;                 // halted
      dcpt_pkg::SRC_PRESC: src_tick = ptick;
      dcpt_pkg::SRC_EVENT: src_tick = !cap && b_edge;
      dcpt_pkg::SRC_ACCUM: src_tick = !cap && ptick && b_act;
      dcpt_pkg::SRC_SLOW:  src_tick = slow;
      default:             src_tick = 1'b0;
    endcase
  endfunction

  // configuration: reset leaves both counters without a clock
  always_comb begin
    next_cfg = cfg;
    if (cfg_wr) begin
      next_cfg = cfg_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= dcpt_pkg::CFG_RST;
    end else begin
      cfg <= next_cfg;
    end
  end

  // prescaler: tick on zero, then reload the programmed value
  always_comb begin
    presc_tick = (presc_cnt == dcpt_pkg::PRSC_RST);
    if (presc_tick) begin
      next_presc_cnt = cfg.prescaler_value;
    end else begin
      next_presc_cnt = presc_cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_cnt <= dcpt_pkg::PRSC_RST;
    end else begin
      presc_cnt <= next_presc_cnt;
    end
  end

  // source selection and capture edges
  always_comb begin
    pwm_mode  = (cfg.mode == dcpt_pkg::MODE_PWM);
    tick_one  = src_tick(cfg.sel_one, !pwm_mode, presc_tick,
                  cfg.evt_rising ? syn_rise[dcpt_pkg::SYN_PIN_B]
                                 : syn_fall[dcpt_pkg::SYN_PIN_B],
                  syn_level[dcpt_pkg::SYN_PIN_B] == cfg.accum_high,
                  syn_rise[dcpt_pkg::SYN_SLOW]);
    tick_two  = src_tick(cfg.sel_two, !pwm_mode, presc_tick,
                  cfg.evt_rising ? syn_rise[dcpt_pkg::SYN_PIN_B]
                                 : syn_fall[dcpt_pkg::SYN_PIN_B],
                  syn_level[dcpt_pkg::SYN_PIN_B] == cfg.accum_high,
                  syn_rise[dcpt_pkg::SYN_SLOW]);
    cap_a_evt = !pwm_mode && (cfg.cap_a_rising ? syn_rise[dcpt_pkg::SYN_PIN_A]
                                               : syn_fall[dcpt_pkg::SYN_PIN_A]);
    cap_b_evt = !pwm_mode && (cfg.cap_b_rising ? syn_rise[dcpt_pkg::SYN_PIN_B]
                                               : syn_fall[dcpt_pkg::SYN_PIN_B]);
    // stopped, left mode 0, or counter one source or mode rewritten
    restart   = !pwm_mode || cfg.sel_one == dcpt_pkg::SRC_NONE ||
                (cfg_wr && (cfg_in.sel_one != cfg.sel_one ||
                            cfg_in.mode != cfg.mode));
  end

  // counters, capture registers, pin a and pending flags
  always_comb begin
    next_cnt1  = counter_one;
    next_cnt2  = counter_two;
    next_cra   = reload_capture_a;
    next_crb   = reload_capture_b;
    next_use_b = use_b;
    next_pin_a = timer_pin_a_out;
    pend_set   = 4'h0;
    // software writes lose against hardware updates below
    case (wr_in.target)
      dcpt_pkg::TGT_CRA:  next_cra  = wr_in.data;
      dcpt_pkg::TGT_CRB:  next_crb  = wr_in.data;
      dcpt_pkg::TGT_CNT1: next_cnt1 = wr_in.data;
      dcpt_pkg::TGT_CNT2: next_cnt2 = wr_in.data;
      default:            next_cnt1 = counter_one;
    endcase
    if (pwm_mode) begin
      if (restart) begin
        next_use_b = 1'b0;
        next_pin_a = cfg.pwm_initial_level;
      end else if (tick_one) begin
        if (counter_one == CNT_ZERO) begin
          // underflow: alternate reload source and toggle pin
          next_cnt1  = use_b ? reload_capture_b : reload_capture_a;
          pend_set[use_b ? dcpt_pkg::PEND_B : dcpt_pkg::PEND_A] = 1'b1;
          next_use_b = !use_b;
          next_pin_a = !timer_pin_a_out;
        end else begin
          next_cnt1 = counter_one - 1'b1;
        end
      end
    end else begin
      next_use_b = 1'b0;
      next_pin_a = cfg.pwm_initial_level;
      if (tick_one) begin
        if (counter_one == CNT_ZERO) begin
          // free running underflow
          next_cnt1 = dcpt_pkg::CNT_PRESET;
          pend_set[dcpt_pkg::PEND_C] = 1'b1;
        end else begin
          next_cnt1 = counter_one - 1'b1;
        end
      end
      if (cap_a_evt) begin
        next_cra = counter_one;
        pend_set[dcpt_pkg::PEND_A] = 1'b1;
      end
      if (cap_b_evt) begin
        next_crb = counter_one;
        pend_set[dcpt_pkg::PEND_B] = 1'b1;
      end
      if ((cap_a_evt && cfg.preset_a) || (cap_b_evt && cfg.preset_b)) begin
        next_cnt1 = dcpt_pkg::CNT_PRESET;
      end
    end
    // counter two: plain timer in both modes
    if (tick_two) begin
      if (counter_two == CNT_ZERO) begin
        next_cnt2 = dcpt_pkg::CNT_PRESET;
        pend_set[dcpt_pkg::PEND_D] = 1'b1;
      end else begin
        next_cnt2 = counter_two - 1'b1;
      end
    end
    // set wins over a clear in the same cycle
    next_pend = (pending_flags & ~pend_clr) | pend_set;
    next_oe   = pwm_mode && cfg.pin_a_function_enable;
    next_irq1 = |(next_pend[2:0] & cfg.irq_enable[2:0]);
    next_irq2 = next_pend[dcpt_pkg::PEND_D] &&
                cfg.irq_enable[dcpt_pkg::PEND_D];
  end

  // state registers: counting moves only on clk edges, so a stopped clk holds it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_one      <= dcpt_pkg::CNT_RST;
      counter_two      <= dcpt_pkg::CNT_RST;
      reload_capture_a <= dcpt_pkg::CNT_RST;
      reload_capture_b <= dcpt_pkg::CNT_RST;
      use_b            <= 1'b0;
      timer_pin_a_out  <= 1'b0;
      timer_pin_a_oe   <= 1'b0;
      pending_flags    <= 4'h0;
      timer_irq_one    <= 1'b0;
      timer_irq_two    <= 1'b0;
    end else begin
      counter_one      <= next_cnt1;
      counter_two      <= next_cnt2;
      reload_capture_a <= next_cra;
      reload_capture_b <= next_crb;
      use_b            <= next_use_b;
      timer_pin_a_out  <= next_pin_a;
      timer_pin_a_oe   <= next_oe;
      pending_flags    <= next_pend;
      timer_irq_one    <= next_irq1;
      timer_irq_two    <= next_irq2;
    end
  end

  // checks on the block's own behaviour
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic sw_idle;  // no data write and no configuration write this cycle
  assign sw_idle = (wr_in.target == dcpt_pkg::TGT_NONE) && !cfg_wr;

  sequence pwm_underflow_s;
    pwm_mode && !restart && tick_one && counter_one == CNT_ZERO && sw_idle;
  endsequence

  sequence cap_a_s;
    cap_a_evt && sw_idle;
  endsequence

  presc_reload_a: assert property (presc_tick && !cfg_wr |=>
    presc_cnt == $past(cfg.prescaler_value))
    else $error("prescaler did not reload its value");

  halt_none_a: assert property (
    cfg.sel_one == dcpt_pkg::SRC_NONE && pwm_mode && sw_idle |=> $stable(counter_one))
    else $error("halted counter one changed");

  cap_stop_a: assert property (!pwm_mode && sw_idle &&
    (cfg.sel_two == dcpt_pkg::SRC_EVENT || cfg.sel_two == dcpt_pkg::SRC_ACCUM)
    |=> $stable(counter_two))
    else $error("counter two ran on pin b in capture mode");

  reload_alt_a: assert property (pwm_underflow_s and !use_b |=>
    counter_one == $past(reload_capture_a) && use_b && pending_flags[dcpt_pkg::PEND_A])
    else $error("first reload not from register a");

  pwm_toggle_a: assert property (pwm_underflow_s |=>
    timer_pin_a_out != $past(timer_pin_a_out))
    else $error("pin a did not toggle on underflow");

  start_a_a: assert property (restart && pwm_mode |=> !use_b)
    else $error("restart did not select register a");

  capture_a_a: assert property (cap_a_s |=>
    reload_capture_a == $past(counter_one) && pending_flags[dcpt_pkg::PEND_A])
    else $error("capture a lost counter value");

  preset_a: assert property (cap_a_s and cfg.preset_a |=>
    counter_one == dcpt_pkg::CNT_PRESET)
    else $error("counter one not preset after capture");

  pend_hold_a: assert property (
    pending_flags[dcpt_pkg::PEND_D] && !pend_clr[dcpt_pkg::PEND_D]
    |=> pending_flags[dcpt_pkg::PEND_D])
    else $error("flag d dropped without a clear");

  irq_two_a: assert property (timer_irq_two |->
    pending_flags[dcpt_pkg::PEND_D] && $past(cfg.irq_enable[dcpt_pkg::PEND_D]))
    else $error("irq two without flag d and enable");

endmodule
`default_nettype wire

// File: dual_counter_pwm_capture_timer_test.sv
// Purpose: self-checking bench with a cycle model of the timer
// Assumes: configuration and pins change one nanosecond after a clock edge
// Notes:   checks run on every cycle, reset and configuration writes included
`timescale 1ns/1ns
`default_nettype none
module dual_counter_pwm_capture_timer_test;
  logic clk = 1'b0;        // system clock
  logic clk_run = 1'b1;    // low stops the clock
  logic rst_n = 1'b0;      // reset, active low
  logic cfg_wr = 1'b0;     // configuration strobe
  dcpt_pkg::dcpt_cfg_s cfg_in = dcpt_pkg::CFG_RST; // configuration word
  dcpt_pkg::dcpt_wr_s  wr_in = '0;   // software data write
  logic [3:0] pend_clr = 4'h0;       // flag clears
  logic want_a = 1'b0;     // asked level of pin a
  logic want_b = 1'b0;     // asked level of pin b
  logic pin_a, pin_b, slow, pa_out, pa_oe, irq1, irq2;
  logic [15:0] cnt1, cnt2, cra, crb;
  logic [3:0] flags;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  // model state
  dcpt_pkg::dcpt_cfg_s mc;
  logic [15:0] m_c1, m_c2, m_ra, m_rb, n1, n2, na, nb;
  logic [3:0] m_fl, st;
  logic [4:0] pd;
  logic m_pa, m_oe, m_i1, m_i2, m_nb, pt, cp, t1, t2, rs;
  logic [2:0] s1, s2, s3, ri, fa;

  always #5 clk = clk_run ? ~clk : clk;

  dcpt_timer dcpt_timer_i (
    .clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
    .wr_in(wr_in), .pend_clr(pend_clr), .timer_pin_a_in(pin_a),
    .timer_pin_b_in(pin_b), .low_speed_clock(slow),
    .timer_pin_a_out(pa_out), .timer_pin_a_oe(pa_oe),
    .counter_one(cnt1), .counter_two(cnt2), .reload_capture_a(cra),
    .reload_capture_b(crb), .pending_flags(flags),
    .timer_irq_one(irq1), .timer_irq_two(irq2));

  dcpt_pins_model dcpt_pins_model_i (
    .clk(clk), .want_a(want_a), .want_b(want_b), .pin_a_out(pa_out),
    .pin_a_oe(pa_oe), .pin_a(pin_a), .pin_b(pin_b), .slow_clk(slow));

  // tick of one counter for a given source
  function logic tick(input dcpt_pkg::dcpt_src_e src);
    case (src)
      dcpt_pkg::SRC_PRESC: tick = pt;
      dcpt_pkg::SRC_EVENT: tick = !cp && (mc.evt_rising ? ri[1] : fa[1]);
      dcpt_pkg::SRC_ACCUM: tick = !cp && pt && (s2[1] == mc.accum_high);
      dcpt_pkg::SRC_SLOW:  tick = ri[2];
      default:             tick = 1'b0;
    endcase
  endfunction

  // cycle model, stepped on the design's own edges
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {m_c1, m_c2, m_ra, m_rb, m_fl, pd} = '0;
      {m_pa, m_oe, m_i1, m_i2, m_nb, s1, s2, s3} = '0;
      mc = dcpt_pkg::CFG_RST;
    end else begin
      pt = (pd == 5'h00);
      ri = s2 & ~s3;
      fa = s3 & ~s2;
      cp = (mc.mode == dcpt_pkg::MODE_CAPTURE);
      t1 = tick(mc.sel_one);
      t2 = tick(mc.sel_two);
      {n1, n2, na, nb, st} = {m_c1, m_c2, m_ra, m_rb, 4'h0};
      case (wr_in.target)
        dcpt_pkg::TGT_CRA:  na = wr_in.data;
        dcpt_pkg::TGT_CRB:  nb = wr_in.data;
        dcpt_pkg::TGT_CNT1: n1 = wr_in.data;
        dcpt_pkg::TGT_CNT2: n2 = wr_in.data;
        default: ;
      endcase
      if (t2) begin
        n2 = (m_c2 == 16'h0000) ? 16'hFFFF : m_c2 - 16'h0001;
        st[3] = (m_c2 == 16'h0000);
      end
      rs = mc.sel_one == dcpt_pkg::SRC_NONE || cp ||
           (cfg_wr && (cfg_in.sel_one != mc.sel_one || cfg_in.mode != mc.mode));
      // a pwm restart cycle holds counter one
      if (t1 && (cp || !rs)) begin
        n1 = m_c1 - 16'h0001;
        if (m_c1 == 16'h0000 && cp) begin
          n1 = 16'hFFFF;
          st[2] = 1'b1;
        end else if (m_c1 == 16'h0000) begin
          n1 = m_nb ? m_rb : m_ra;
          st[m_nb ? 1 : 0] = 1'b1;
          m_pa = ~m_pa;
          m_nb = ~m_nb;
        end
      end
      if (cp && (mc.cap_a_rising ? ri[0] : fa[0])) begin
        na = m_c1;
        st[0] = 1'b1;
        if (mc.preset_a) n1 = 16'hFFFF;
      end
      if (cp && (mc.cap_b_rising ? ri[1] : fa[1])) begin
        nb = m_c1;
        st[1] = 1'b1;
        if (mc.preset_b) n1 = 16'hFFFF;
      end
      if (rs) begin
        m_pa = mc.pwm_initial_level;
        m_nb = 1'b0;
      end
      {m_c1, m_c2, m_ra, m_rb} = {n1, n2, na, nb};
      m_fl = (m_fl & ~pend_clr) | st;
      m_i1 = |(m_fl[2:0] & mc.irq_enable[2:0]);
      m_i2 = m_fl[3] & mc.irq_enable[3];
      m_oe = !cp && mc.pin_a_function_enable;
      pd = pt ? mc.prescaler_value : pd - 5'h01;
      if (cfg_wr) mc = cfg_in;
      s3 = s2;
      s2 = s1;
      s1 = {slow, pin_b, pin_a};
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // compare every cycle once the edge has settled
  always @(posedge clk) begin
    #3;
    chk(cnt1, m_c1);
    chk(cnt2, m_c2);
    chk(cra, m_ra);
    chk(crb, m_rb);
    chk(16'(flags), 16'(m_fl));
    chk(16'(pa_out), 16'(m_pa));
    chk(16'(pa_oe), 16'(m_oe));
    chk(16'(irq1), 16'(m_i1));
    chk(16'(irq2), 16'(m_i2));
  end

  // random pins, clears and writes for n cycles
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      cfg_wr = 1'b0;
      wr_in.target = dcpt_pkg::TGT_NONE;
      pend_clr = ($urandom % 16 == 0) ? 4'($urandom) : 4'h0;
      if ($urandom % 4 == 0) want_a = 1'($urandom);
      if ($urandom % 4 == 0) want_b = 1'($urandom);
      if ($urandom % 12 == 0) begin
        wr_in.target = dcpt_pkg::dcpt_tgt_e'(3'(1 + $urandom % 4));
        wr_in.data = 16'($urandom % 8);
      end
    end
  endtask

  task automatic set_cfg(input dcpt_pkg::dcpt_cfg_s c);
    @(posedge clk);
    #1;
    cfg_in = c;
    cfg_wr = 1'b1;
    cyc(1);
  endtask

  task automatic stop_test();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    dcpt_pkg::dcpt_cfg_s c;
    void'($urandom(32'h1ae49884));
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cyc(20);
    c = dcpt_pkg::CFG_RST;
    c.pin_a_function_enable = 1'b1;
    c.pwm_initial_level = 1'b1;
    c.irq_enable = 4'hF;
    set_cfg(c);
    for (int s = 1; s < 5; s++) begin
      c.sel_one = dcpt_pkg::dcpt_src_e'(s);
      c.sel_two = dcpt_pkg::dcpt_src_e'(5 - s);
      c.evt_rising = 1'($urandom);
      c.accum_high = 1'($urandom);
      c.prescaler_value = (s == 2) ? 5'h1F : 5'($urandom % 3);
      set_cfg(c);
      cyc(300);
      c.sel_one = dcpt_pkg::SRC_NONE;
      set_cfg(c);
      cyc(5);
    end
    c.mode = dcpt_pkg::MODE_CAPTURE;
    for (int s = 1; s < 5; s++) begin
      c.sel_one = dcpt_pkg::dcpt_src_e'(s);
      c.sel_two = dcpt_pkg::dcpt_src_e'(5 - s);
      {c.cap_a_rising, c.cap_b_rising, c.preset_a, c.preset_b} = 4'($urandom);
      c.irq_enable = 4'($urandom);
      set_cfg(c);
      cyc(300);
    end
    c.mode = dcpt_pkg::MODE_PWM;
    c.sel_one = dcpt_pkg::SRC_PRESC;
    set_cfg(c);
    cyc(100);
    clk_run = 1'b0;
    #300;
    clk_run = 1'b1;
    cyc(100);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(30);
    stop_test();
  end
endmodule
`default_nettype wire
